// ---- logic/addr_shadow.sv ----
/*
 * Shadow copies of the area start addresses, loaded at display update
 * or capture vertical sync.
 * Assumes update inputs synchronous to pclk.
 */
`timescale 1ns/100ps
module addr_shadow
(
    input wire logic pclk,
    input wire logic presetn,
    field_bus_if.dst fb,
    input wire logic disp_update,
    input wire logic capture_vertical_sync_in,
    output area_win_pkg::phys_addr_t vid1_disp_addr,
    output area_win_pkg::phys_addr_t vid2_disp_addr,
    output area_win_pkg::phys_addr_t vid1_cap_addr,
    output area_win_pkg::phys_addr_t vid2_cap_addr,
    output area_win_pkg::phys_addr_t cur1_shape_a,
    output area_win_pkg::phys_addr_t cur1_shape_b,
    output area_win_pkg::phys_addr_t cur2_shape_a,
    output area_win_pkg::phys_addr_t cur2_shape_b
);
    import area_win_pkg::*;
    logic vsync_prev_ff;
    logic cap_edge;
    // Rising edge of capture sync; reset high so no false edge
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            vsync_prev_ff <= 1'b1;
        else
            vsync_prev_ff <= capture_vertical_sync_in;
    end
    assign cap_edge = capture_vertical_sync_in & ~vsync_prev_ff;
    // Display side copies, held through reset
    always_ff @(posedge pclk)
    begin
        if (disp_update)
        begin
            vid1_disp_addr <= {fb.vid1_high, fb.vid1_low, 10'h000}; // RQ16 RQ17 RQ18
            vid2_disp_addr <= {fb.vid2_high, fb.vid2_low, 10'h000}; // RQ16 RQ17 RQ18
            cur1_shape_a <= {fb.cur1_high, fb.cur1_low, 11'h000}; // RQ5 RQ7 RQ9
            cur1_shape_b <= {fb.cur1_high, fb.cur1_low, 1'b1, 10'h000}; // RQ6
            cur2_shape_a <= {fb.cur2_high, fb.cur2_low, 11'h000}; // RQ5 RQ7 RQ9
            cur2_shape_b <= {fb.cur2_high, fb.cur2_low, 1'b1, 10'h000}; // RQ6
        end
    end
    // Capture side copies, taken at sync rise
    always_ff @(posedge pclk)
    begin
        if (cap_edge)
        begin
            vid1_cap_addr <= {fb.vid1_high, fb.vid1_low, 10'h000}; // RQ17
            vid2_cap_addr <= {fb.vid2_high, fb.vid2_low, 10'h000}; // RQ17
        end
    end
endmodule

// ---- logic/area_win_bank.sv ----
/*
 * APB register bank for video, cursor and render area start addresses,
 * video window size and display window positions.
 * Assumes APB3 master, 32-bit data, registers on aligned words, and
 * display update and timing strobes synchronous to pclk.
 */
// Local design decision: the APB slave port.
`include "area_win_regs.svh"
`timescale 1ns/100ps
module area_win_bank
#(
    parameter int ADDR_W = 13
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic disp_update,
    input wire logic capture_vertical_sync_in,
    input wire logic dot_tick,
    input wire logic line_start,
    input wire logic frame_start,
    output area_win_pkg::phys_addr_t vid1_disp_addr,
    output area_win_pkg::phys_addr_t vid2_disp_addr,
    output area_win_pkg::phys_addr_t vid1_cap_addr,
    output area_win_pkg::phys_addr_t vid2_cap_addr,
    output area_win_pkg::phys_addr_t cur1_shape_a,
    output area_win_pkg::phys_addr_t cur1_shape_b,
    output area_win_pkg::phys_addr_t cur2_shape_a,
    output area_win_pkg::phys_addr_t cur2_shape_b,
    output area_win_pkg::phys_addr_t render_addr,
    output logic render_addr_valid,
    output logic [9:0] window_width,
    output logic [8:0] window_height,
    output area_win_pkg::pos_count_t h_pos,
    output area_win_pkg::pos_count_t v_pos,
    output logic visible
);
    import area_win_pkg::*;

    // ----------------------------------------
    // Decode helpers
    // ----------------------------------------

    // Registers stored in this bank
    function automatic logic is_held(input reg_index_t idx);
        case (idx)
            `IDX_H_BEGIN, `IDX_H_END, `IDX_V_BEGIN, `IDX_V_END,
            `IDX_VID1_HIGH, `IDX_VID1_LOW, `IDX_VID2_HIGH, `IDX_VID2_LOW,
            `IDX_WIN_WIDTH, `IDX_WIN_HEIGHT, `IDX_CUR1, `IDX_CUR2,
            `IDX_RENDER, `IDX_RENDER_MODE, `IDX_STATUS:
                is_held = 1'b1;
            default:
                is_held = 1'b0;
        endcase
    endfunction

    // Display timing control address ranges
    function automatic logic in_timing_range(input reg_index_t idx);
        in_timing_range = (idx >= 11'h026 && idx <= 11'h03c)
            || (idx >= 11'h052 && idx <= 11'h054)
            || (idx >= 11'h058 && idx <= 11'h05a)
            || (idx >= 11'h074 && idx <= 11'h07a)
            || (idx >= 11'h200 && idx <= 11'h5fe); // RQ12
    endfunction

    // ----------------------------------------
    // Field storage
    // ----------------------------------------

    field_bus_if fb ();
    logic [9:1] width_ff;
    logic [8:1] height_ff;
    logic [6:0] render_high_ff;
    logic render_en_ff;
    logic cur_pending_ff;
    logic nxt_cur_pending;
    logic [31:0] prdata_ff;
    reg_index_t idx;
    reg_word_t wd;
    reg_word_t rd_word;
    logic aligned;
    logic access;
    logic wr_en;
    logic cur_wr;

    // Bus decode
    assign idx = paddr[12:2];
    assign wd = pwdata[15:0];
    assign aligned = (paddr[1:0] == 2'b00);
    assign access = psel & penable;
    assign wr_en = access & pwrite & aligned;
    assign cur_wr = wr_en && (idx == `IDX_CUR1 || idx == `IDX_CUR2);

    // Video area address fields, no reset
    always_ff @(posedge pclk)
    begin
        if (wr_en && idx == `IDX_VID1_HIGH)
            fb.vid1_high <= wd[`HIGH_MSB:0]; // RQ4 RQ16
        if (wr_en && idx == `IDX_VID1_LOW)
            fb.vid1_low <= wd[15:`VID_LOW_LSB]; // RQ4 RQ16
        if (wr_en && idx == `IDX_VID2_HIGH)
            fb.vid2_high <= wd[`HIGH_MSB:0]; // RQ4 RQ16
        if (wr_en && idx == `IDX_VID2_LOW)
            fb.vid2_low <= wd[15:`VID_LOW_LSB]; // RQ4 RQ16
    end

    // Cursor area address fields, no reset
    always_ff @(posedge pclk)
    begin
        if (wr_en && idx == `IDX_CUR1)
        begin
            fb.cur1_high <= wd[`HIGH_MSB:0]; // RQ4 RQ5 RQ9
            fb.cur1_low <= wd[15:`CUR_LOW_LSB]; // RQ5 RQ15
        end
        if (wr_en && idx == `IDX_CUR2)
        begin
            fb.cur2_high <= wd[`HIGH_MSB:0]; // RQ4 RQ5 RQ9
            fb.cur2_low <= wd[15:`CUR_LOW_LSB]; // RQ5 RQ15
        end
    end

    // Window size fields, bit 0 not stored
    always_ff @(posedge pclk)
    begin
        if (wr_en && idx == `IDX_WIN_WIDTH)
            width_ff <= wd[`WIDTH_MSB:1]; // RQ2 RQ4
        if (wr_en && idx == `IDX_WIN_HEIGHT)
            height_ff <= wd[`HEIGHT_MSB:1]; // RQ2 RQ4
    end

    // Display window position fields, no reset
    always_ff @(posedge pclk)
    begin
        if (wr_en && idx == `IDX_H_BEGIN)
            fb.h_begin <= wd[`H_BEGIN_MSB:0]; // RQ4 RQ13
        if (wr_en && idx == `IDX_H_END)
            fb.h_end <= wd[`H_END_MSB:0]; // RQ4 RQ13
        if (wr_en && idx == `IDX_V_BEGIN)
            fb.v_begin <= wd[`V_BEGIN_MSB:0]; // RQ4 RQ14
        if (wr_en && idx == `IDX_V_END)
            fb.v_end <= wd[`V_END_MSB:0]; // RQ4 RQ14
    end

    // Render area address, no reset
    always_ff @(posedge pclk)
    begin
        if (wr_en && idx == `IDX_RENDER)
            render_high_ff <= wd[`HIGH_MSB:0]; // RQ4 RQ11
    end

    // Render mode enable, cleared at reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            render_en_ff <= `RENDER_MODE_RST;
        else if (wr_en && idx == `IDX_RENDER_MODE)
            render_en_ff <= wd[`RENDER_EN_BIT];
    end

    // Cursor change waiting for update; write wins over update
    always_comb
    begin
        nxt_cur_pending = cur_pending_ff;
        if (cur_wr)
            nxt_cur_pending = 1'b1;
        else if (disp_update)
            nxt_cur_pending = 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cur_pending_ff <= 1'b0;
        else
            cur_pending_ff <= nxt_cur_pending; // RQ7
    end

    // ----------------------------------------
    // Read path
    // ----------------------------------------

    // Read word; unused bits return zero
    always_comb
    begin
        rd_word = 16'h0000; // RQ3
        case (idx)
            `IDX_H_BEGIN:
                rd_word = {7'h00, fb.h_begin};
            `IDX_H_END:
                rd_word = {6'h00, fb.h_end};
            `IDX_V_BEGIN:
                rd_word = {7'h00, fb.v_begin};
            `IDX_V_END:
                rd_word = {6'h00, fb.v_end};
            `IDX_VID1_HIGH:
                rd_word = {9'h000, fb.vid1_high};
            `IDX_VID1_LOW:
                rd_word = {fb.vid1_low, 10'h000};
            `IDX_VID2_HIGH:
                rd_word = {9'h000, fb.vid2_high};
            `IDX_VID2_LOW:
                rd_word = {fb.vid2_low, 10'h000};
            `IDX_WIN_WIDTH:
                rd_word = {6'h00, width_ff, 1'b0}; // RQ2
            `IDX_WIN_HEIGHT:
                rd_word = {7'h00, height_ff, 1'b0}; // RQ2
            `IDX_CUR1:
                rd_word = {fb.cur1_low, 4'h0, fb.cur1_high}; // RQ15
            `IDX_CUR2:
                rd_word = {fb.cur2_low, 4'h0, fb.cur2_high}; // RQ15
            `IDX_RENDER:
                rd_word = {9'h000, render_high_ff};
            `IDX_RENDER_MODE:
                rd_word = {15'h0000, render_en_ff};
            `IDX_STATUS:
                rd_word = {14'h0000, cur_pending_ff, visible};
            default:
                rd_word = 16'h0000;
        endcase
    end

    // Read data taken in the setup cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_ff <= 32'h0000_0000;
        else if (psel && !penable && !pwrite)
            prdata_ff <= {16'h0000, rd_word};
    end

    // Zero wait states; error on unmapped or misaligned
    assign prdata = prdata_ff;
    assign pready = 1'b1;
    assign pslverr = access & (~aligned | ~(is_held(idx) | in_timing_range(idx))); // RQ12

    // ----------------------------------------
    // Derived outputs
    // ----------------------------------------

    // Render address only while enabled
    assign render_addr_valid = render_en_ff; // RQ10
    assign render_addr = render_en_ff ? {render_high_ff, 16'h0000} : 23'h000000; // RQ10 RQ18
    assign window_width = {width_ff, 1'b0}; // RQ1 RQ2
    assign window_height = {height_ff, 1'b0}; // RQ1 RQ2

    // Shadowed area start addresses
    addr_shadow u_shadow
    (
        .pclk(pclk),
        .presetn(presetn),
        .fb(fb),
        .disp_update(disp_update),
        .capture_vertical_sync_in(capture_vertical_sync_in),
        .vid1_disp_addr(vid1_disp_addr),
        .vid2_disp_addr(vid2_disp_addr),
        .vid1_cap_addr(vid1_cap_addr),
        .vid2_cap_addr(vid2_cap_addr),
        .cur1_shape_a(cur1_shape_a),
        .cur1_shape_b(cur1_shape_b),
        .cur2_shape_a(cur2_shape_a),
        .cur2_shape_b(cur2_shape_b)
    );

    // Visible window generation
    window_gen u_window
    (
        .pclk(pclk),
        .presetn(presetn),
        .fb(fb),
        .dot_tick(dot_tick),
        .line_start(line_start),
        .frame_start(frame_start),
        .h_pos(h_pos),
        .v_pos(v_pos),
        .visible(visible)
    );
endmodule

// ---- logic/area_win_pkg.sv ----
/*
 * Types shared by the area address and display window bank.
 * Assumes nothing beyond the register header.
 */
package area_win_pkg;
    typedef logic [22:0] phys_addr_t;
    typedef logic [15:0] reg_word_t;
    typedef logic [10:0] reg_index_t;
    typedef logic [10:0] pos_count_t;
endpackage

// ---- logic/area_win_regs.svh ----
/*
 * Register indices, field positions and widths of the area address and
 * display window register bank.
 * Assumes byte address = 4 x index on a 32-bit APB bus.
 */
// How it works
// RQ1 - Software programs window size times reduction ratio
// RQ2 - Window size fields always even, width bits 9:1
// RQ3 - Unused bits written zero, read back undefined
// RQ4 - Field contents kept through reset
// RQ5 - Cursor address: high A22-A16, low A15-A11
// RQ6 - Cursor shapes: two consecutive 1024-byte blocks
// RQ7 - Cursor address applied at next display update
// RQ8 - Cursor shape data stored linearly by software
// RQ9 - Two independent cursor address pairs
// RQ10 - Render address used only while enable set
// RQ11 - Render address holds A22-A16 in bits 6:0
// RQ12 - Display timing registers decode in listed ranges
// RQ13 - Horizontal window counted in dot-clock periods
// RQ14 - Vertical window counted in raster lines
// RQ15 - Cursor reserved bits 10:7 written zero
// RQ16 - Video address pair holds A22-A10 only
// RQ17 - Video address applied at update or capture vsync
// RQ18 - Lower address bits filled with zero
`ifndef AREA_WIN_REGS_SVH
`define AREA_WIN_REGS_SVH
// ----------------------------------------
// Register indices
// ----------------------------------------
`define IDX_H_BEGIN 11'h026
`define IDX_H_END 11'h028
`define IDX_V_BEGIN 11'h02a
`define IDX_V_END 11'h02c
`define IDX_VID1_HIGH 11'h066
`define IDX_VID1_LOW 11'h068
`define IDX_VID2_HIGH 11'h06a
`define IDX_VID2_LOW 11'h06c
`define IDX_WIN_WIDTH 11'h06e
`define IDX_WIN_HEIGHT 11'h070
`define IDX_CUR1 11'h07c
`define IDX_CUR2 11'h07e
`define IDX_RENDER 11'h098
`define IDX_RENDER_MODE 11'h09a
`define IDX_STATUS 11'h09c
// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define HIGH_MSB 6
`define VID_LOW_LSB 10
`define CUR_LOW_LSB 11
`define WIDTH_MSB 9
`define HEIGHT_MSB 8
`define H_BEGIN_MSB 8
`define H_END_MSB 9
`define V_BEGIN_MSB 8
`define V_END_MSB 9
`define RENDER_EN_BIT 0
`define RENDER_MODE_RST 1'b0
`define CUR_SHAPE_BYTES 1024
`endif

// ---- logic/field_bus_if.sv ----
/*
 * Programmed register fields passed from the register bank to the
 * address shadow and window generator modules.
 * Assumes one driver, the register bank.
 */
`timescale 1ns/100ps
interface field_bus_if;
    logic [6:0] vid1_high;
    logic [5:0] vid1_low;
    logic [6:0] vid2_high;
    logic [5:0] vid2_low;
    logic [6:0] cur1_high;
    logic [4:0] cur1_low;
    logic [6:0] cur2_high;
    logic [4:0] cur2_low;
    logic [8:0] h_begin;
    logic [9:0] h_end;
    logic [8:0] v_begin;
    logic [9:0] v_end;
    modport src (output vid1_high, vid1_low, vid2_high, vid2_low, cur1_high, cur1_low,
        cur2_high, cur2_low, h_begin, h_end, v_begin, v_end);
    modport dst (input vid1_high, vid1_low, vid2_high, vid2_low, cur1_high, cur1_low,
        cur2_high, cur2_low, h_begin, h_end, v_begin, v_end);
endinterface

// ---- logic/window_gen.sv ----
/*
 * Visible display window from dot and line counters.
 * Assumes dot_tick, line_start and frame_start one-cycle pulses.
 */
`timescale 1ns/100ps
module window_gen
(
    input wire logic pclk,
    input wire logic presetn,
    field_bus_if.dst fb,
    input wire logic dot_tick,
    input wire logic line_start,
    input wire logic frame_start,
    output area_win_pkg::pos_count_t h_pos,
    output area_win_pkg::pos_count_t v_pos,
    output logic visible
);
    import area_win_pkg::*;
    pos_count_t h_ff;
    pos_count_t v_ff;
    logic vis_ff;
    // Dot periods along the line
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            h_ff <= 11'h000;
        else if (line_start)
            h_ff <= 11'h000;
        else if (dot_tick)
            h_ff <= h_ff + 11'h001; // RQ13
    end
    // Raster lines in the frame
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            v_ff <= 11'h000;
        else if (frame_start)
            v_ff <= 11'h000;
        else if (line_start)
            v_ff <= v_ff + 11'h001; // RQ14
    end
    // Inside begin..end-1 on both axes
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            vis_ff <= 1'b0;
        else
            vis_ff <= (h_ff >= {2'b00, fb.h_begin}) && (h_ff < {1'b0, fb.h_end})
                && (v_ff >= {2'b00, fb.v_begin}) && (v_ff < {1'b0, fb.v_end}); // RQ13 RQ14
    end
    assign h_pos = h_ff;
    assign v_pos = v_ff;
    assign visible = vis_ff;
endmodule

// ---- verif/area_win_bank_tb.sv ----
/*
 * Self-checking bench for the area address and display window bank.
 * Assumes the bank, its package, interface and register header.
 */
`include "area_win_regs.svh"
`timescale 1ns/100ps
module area_win_bank_tb;
    import area_win_pkg::*;
    localparam logic [10:0] IDXS [13] = '{`IDX_H_BEGIN, `IDX_H_END, `IDX_V_BEGIN, `IDX_V_END,
        `IDX_VID1_HIGH, `IDX_VID1_LOW, `IDX_VID2_HIGH, `IDX_VID2_LOW, `IDX_WIN_WIDTH,
        `IDX_WIN_HEIGHT, `IDX_CUR1, `IDX_CUR2, `IDX_RENDER};
    localparam logic [15:0] MSKS [13] = '{16'h01ff, 16'h03ff, 16'h01ff, 16'h03ff, 16'h007f,
        16'hfc00, 16'h007f, 16'hfc00, 16'h03fe, 16'h01fe, 16'hf87f, 16'hf87f, 16'h007f};
    localparam logic [12:0] BADS [8] = '{13'h00c0, 13'h00f0, 13'h0800, 13'h17f8, 13'h0094,
        13'h00f4, 13'h1800, 13'h009a};
    localparam logic ERRS [8] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic [12:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic disp_update, capture_vertical_sync_in, dot_tick, line_start, frame_start;
    phys_addr_t v1d, v2d, v1c, v2c, c1a, c1b, c2a, c2b, raddr;
    logic rvalid, visible;
    logic [9:0] wwidth;
    logic [8:0] wheight;
    pos_count_t h_pos, v_pos;
    int err_count, checks_done, mh, mv;
    area_win_bank dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .disp_update(disp_update),
        .capture_vertical_sync_in(capture_vertical_sync_in), .dot_tick(dot_tick),
        .line_start(line_start), .frame_start(frame_start), .vid1_disp_addr(v1d),
        .vid2_disp_addr(v2d), .vid1_cap_addr(v1c), .vid2_cap_addr(v2c), .cur1_shape_a(c1a),
        .cur1_shape_b(c1b), .cur2_shape_a(c2a), .cur2_shape_b(c2b), .render_addr(raddr),
        .render_addr_valid(rvalid), .window_width(wwidth), .window_height(wheight),
        .h_pos(h_pos), .v_pos(v_pos), .visible(visible));
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic [12:0] a, input logic w, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [10:0] idx, input logic [31:0] d);
        apb({idx, 2'b00}, 1'b1, d);
        #1;
    endtask
    task automatic rdc(input string what, input logic [10:0] idx, input logic [31:0] exp);
        apb({idx, 2'b00}, 1'b0, 32'h0);
        chk(what, exp, rd);
    endtask
    task automatic pulse_upd;
        @(posedge pclk);
        disp_update <= 1'b1;
        @(posedge pclk);
        disp_update <= 1'b0;
        #1;
    endtask
    // One timing strobe, then position and window flag against the model, not checked after a frame strobe
    task automatic step(input logic d, input logic l, input logic f);
        @(posedge pclk);
        {dot_tick, line_start, frame_start} <= {d, l, f};
        @(posedge pclk);
        {dot_tick, line_start, frame_start} <= 3'b000;
        if (f)
            mv = 0;
        else if (l)
        begin
            mh = 0;
            mv++;
        end
        else
            mh++;
        @(posedge pclk);
        #1;
        if (!f)
        begin
            chk("h_pos", mh, h_pos);
            chk("v_pos", mv, v_pos);
            chk("visible", mh >= 2 && mh < 5 && mv >= 1 && mv < 3, visible);
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // ----------------------------------------
    // Clock, watchdog and tests
    // ----------------------------------------
    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    // Cuts a hang short after about 20000 cycles
    initial
    begin
        #2000000;
        err_count++;
        end_of_test;
    end
    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {disp_update, capture_vertical_sync_in, dot_tick, line_start, frame_start} = '0;
        err_count = 0;
        checks_done = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        // Field widths and unused bits
        for (int i = 0; i < 13; i++)
        begin
            wr(IDXS[i], {16'h0, MSKS[i]});
            rdc("field", IDXS[i], {16'h0, MSKS[i]});
        end
        chk("window_width", 10'h3fe, wwidth);
        chk("window_height", 9'h1fe, wheight);
        $display("test fields done");
        // Timing ranges, unmapped and misaligned places
        for (int i = 0; i < 8; i++)
        begin
            apb(BADS[i], 1'b1, 32'h0);
            chk("write err", ERRS[i], er);
            apb(BADS[i], 1'b0, 32'h0);
            chk("read err", ERRS[i], er);
            chk("read data", i == 7 ? 32'h1ff : 32'h0, rd);
        end
        rdc("h_begin kept", `IDX_H_BEGIN, 32'h1ff);
        $display("test decode done");
        // Render address gated by enable
        wr(`IDX_RENDER, 32'h55);
        wr(`IDX_RENDER_MODE, 32'h0);
        chk("render off", 23'h0, raddr);
        wr(`IDX_RENDER_MODE, 32'h1);
        chk("render on", {7'h55, 16'h0}, raddr);
        chk("render valid", 1'b1, rvalid);
        $display("test render done");
        // Cursor and video shadows at display update
        wr(`IDX_CUR1, 32'ha82a);
        wr(`IDX_CUR2, 32'h5011);
        wr(`IDX_VID1_HIGH, 32'h33);
        wr(`IDX_VID1_LOW, 32'hf000);
        wr(`IDX_VID2_HIGH, 32'h05);
        wr(`IDX_VID2_LOW, 32'h0400);
        pulse_upd;
        chk("cur1 a", {7'h2a, 5'h15, 11'h0}, c1a);
        chk("cur1 b", {7'h2a, 5'h15, 11'h0} + 23'd1024, c1b);
        chk("cur2 a", {7'h11, 5'h0a, 11'h0}, c2a);
        chk("cur2 b", {7'h11, 5'h0a, 11'h0} + 23'd1024, c2b);
        chk("vid1 disp", {7'h33, 6'h3c, 10'h0}, v1d);
        chk("vid2 disp", {7'h05, 6'h01, 10'h0}, v2d);
        wr(`IDX_CUR1, 32'h0001);
        apb({`IDX_STATUS, 2'b00}, 1'b0, 32'h0);
        chk("pending", 1'b1, rd[1]);
        chk("cur1 held", {7'h2a, 5'h15, 11'h0}, c1a);
        pulse_upd;
        chk("cur1 new", {7'h01, 16'h0}, c1a);
        apb({`IDX_STATUS, 2'b00}, 1'b0, 32'h0);
        chk("pending clear", 1'b0, rd[1]);
        $display("test cursor done");
        // Capture shadows only at the sync rise
        wr(`IDX_VID1_HIGH, 32'h44);
        wr(`IDX_VID1_LOW, 32'h0800);
        @(posedge pclk);
        capture_vertical_sync_in <= 1'b1;
        @(posedge pclk);
        #1;
        chk("vid1 cap", {7'h44, 6'h02, 10'h0}, v1c);
        chk("vid2 cap", {7'h05, 6'h01, 10'h0}, v2c);
        chk("vid1 disp held", {7'h33, 6'h3c, 10'h0}, v1d);
        wr(`IDX_VID1_HIGH, 32'h11);
        chk("vid1 cap held", {7'h44, 6'h02, 10'h0}, v1c);
        $display("test capture done");
        // Fields survive a reset
        @(posedge pclk);
        capture_vertical_sync_in <= 1'b0;
        presetn <= 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rdc("width kept", `IDX_WIN_WIDTH, 32'h3fe);
        rdc("cur1 kept", `IDX_CUR1, 32'h0001);
        rdc("render kept", `IDX_RENDER, 32'h55);
        chk("render reset", 23'h0, raddr);
        chk("render valid reset", 1'b0, rvalid);
        chk("cur1 a kept", {7'h01, 16'h0}, c1a);
        $display("test reset done");
        // Visible window from dot and line counts
        wr(`IDX_H_BEGIN, 32'h2);
        wr(`IDX_H_END, 32'h5);
        wr(`IDX_V_BEGIN, 32'h1);
        wr(`IDX_V_END, 32'h3);
        step(1'b0, 1'b0, 1'b1);
        for (int l = 0; l < 4; l++)
        begin
            step(1'b0, 1'b1, 1'b0);
            for (int k = 0; k < 8; k++)
                step(1'b1, 1'b0, 1'b0);
        end
        $display("test window done");
        end_of_test;
    end
endmodule

// ---- verif/area_win_checker.sv ----
/*
 * Port assertions for the area address and display window bank.
 * Assumes binding into area_win_bank, one clock domain on pclk.
 */
`timescale 1ns/100ps
module area_win_checker
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pslverr,
    input wire logic disp_update,
    input wire logic capture_vertical_sync_in,
    input wire logic dot_tick,
    input wire logic line_start,
    input wire logic frame_start,
    input area_win_pkg::phys_addr_t vid1_disp_addr,
    input area_win_pkg::phys_addr_t vid1_cap_addr,
    input area_win_pkg::phys_addr_t cur1_shape_a,
    input area_win_pkg::phys_addr_t cur1_shape_b,
    input area_win_pkg::phys_addr_t cur2_shape_a,
    input area_win_pkg::phys_addr_t cur2_shape_b,
    input area_win_pkg::phys_addr_t render_addr,
    input wire logic render_addr_valid,
    input area_win_pkg::pos_count_t h_pos,
    input area_win_pkg::pos_count_t v_pos
);
    import area_win_pkg::*;
    logic upd_seen_ff;
    // ----------------------------------------
    // Helper logic
    // ----------------------------------------
    // Shadows hold real values once loaded
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            upd_seen_ff <= 1'b0;
        else if (disp_update)
            upd_seen_ff <= 1'b1;
    end
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    err_in_access_a: assert property (pslverr |-> psel && penable)
        else $error("pslverr outside access phase");
    render_gate_a: assert property (!render_addr_valid |-> render_addr == 23'h0)
        else $error("render address seen while disabled");
    render_low_a: assert property (render_addr_valid |-> render_addr[15:0] == 16'h0)
        else $error("render address low bits not zero");
    cur_pair_a: assert property (disp_update |=> cur1_shape_b == cur1_shape_a + 23'd1024
        && cur2_shape_b == cur2_shape_a + 23'd1024) else $error("cursor shape b not a plus 1024");
    cur_low_a: assert property (disp_update |=> cur1_shape_a[10:0] == 11'h0
        && cur2_shape_a[10:0] == 11'h0) else $error("cursor address low bits not zero");
    cur_hold_a: assert property (upd_seen_ff && !disp_update |=> $stable(cur1_shape_a)
        && $stable(cur2_shape_a)) else $error("cursor address moved without update");
    vid_low_a: assert property (disp_update |=> vid1_disp_addr[9:0] == 10'h0)
        else $error("video address low bits not zero");
    cap_edge_a: assert property ($changed(vid1_cap_addr) |->
        $past(capture_vertical_sync_in) && !$past(capture_vertical_sync_in, 2))
        else $error("capture address moved without sync rise");
    h_count_a: assert property (dot_tick && !line_start && !frame_start |=>
        h_pos == $past(h_pos) + 11'd1) else $error("h_pos did not count dot tick");
    v_count_a: assert property (line_start && !frame_start |=>
        v_pos == $past(v_pos) + 11'd1 && h_pos == 11'h0) else $error("v_pos line count wrong");
    // Main scenarios reached
    cover property (disp_update);
    cover property ($rose(capture_vertical_sync_in));
    cover property (pslverr);
    cover property ($rose(render_addr_valid));
endmodule

bind area_win_bank area_win_checker chk
(
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pslverr(pslverr),
    .disp_update(disp_update), .capture_vertical_sync_in(capture_vertical_sync_in),
    .dot_tick(dot_tick), .line_start(line_start), .frame_start(frame_start),
    .vid1_disp_addr(vid1_disp_addr), .vid1_cap_addr(vid1_cap_addr),
    .cur1_shape_a(cur1_shape_a), .cur1_shape_b(cur1_shape_b),
    .cur2_shape_a(cur2_shape_a), .cur2_shape_b(cur2_shape_b),
    .render_addr(render_addr), .render_addr_valid(render_addr_valid),
    .h_pos(h_pos), .v_pos(v_pos)
);
